// ==== bench/tb_tss_switch.sv ====
// Bench for the time-slot switch against a memory model
`timescale 1ns/10ps
module tb_tss_switch
  import tss_pkg::*;
();
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic gate = 1'b0;
  logic run = 1'b1;
  logic chk_en = 1'b0;
  logic bclk, fsync, cst, e;
  logic [STREAMS-1:0] sin, sout, soe_n;
  tss_cpu_in_t cin = '{cs_n: 1'b1, default: '0};
  tss_cpu_out_t cout;
  int ph, bk, ch, p, n_mismatch = 0, num_checks = 0, cyc = 0;
  logic [31:0] rs = 32'hB9399012;
  logic [7:0] lo [STREAMS][CHANNELS];
  logic [2:0] hi [STREAMS][CHANNELS];
  logic [7:0] ctrl, rd, b;
  always #5 clk_sys = ~clk_sys;
  tss_line_src u_tss_line_src (.clk_sys(clk_sys), .run(run), .bit_clock_in(bclk),
    .frame_sync_in(fsync), .serial_in_lines(sin), .ph(ph), .bk(bk));
  tss_switch u_tss_switch (.clk_sys(clk_sys), .sys_rst(sys_rst), .bit_clock_in(bclk),
    .frame_sync_in(fsync), .serial_output_gate(gate), .serial_in_lines(sin),
    .serial_out_lines(sout), .serial_out_oe_n(soe_n), .control_bit_serial_out(cst),
    .cpu_in(cin), .cpu_out(cout));
  function automatic logic [7:0] in_byte(int s, int c);
    return 8'h5A ^ {s[2:0], c[4:0]};
  endfunction
  function automatic logic [31:0] xs(logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One access, held until the ack pin is pulled low
  task automatic acc(logic rw, logic [5:0] a, logic [7:0] d);
    int n;
    n = 0;
    @(negedge clk_sys);
    cin <= '{cs_n: 1'b0, ds: 1'b1, rw: rw, addr: a, wdata: d};
    do begin
      @(negedge clk_sys);
      n++;
    end while (cout.ack_oe_n !== 1'b0 && n < 20);
    chk({7'h0, cout.ack_oe_n}, 8'h00);
    rd = cout.rdata;
    cin <= '{cs_n: 1'b1, default: '0};
  endtask
  task automatic setc(logic [7:0] v);
    acc(1'b0, 6'h00, v);
    ctrl = v;
  endtask
  // Hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      n_mismatch++;
      test_done();
    end
  end
  // Mid-cell compare of every output lane and the control bit
  always @(negedge clk_sys)
    if (chk_en && ph == 20 && bk[0]) begin
      ch = bk[8:4];
      p = bk[3:1];
      for (int s = 0; s < STREAMS; s++) begin
        b = (ctrl[6] || hi[s][ch][2]) ? lo[s][ch] : in_byte(lo[s][ch][7:5], lo[s][ch][4:0]);
        e = gate && (ctrl[6] || hi[s][ch][0]);
        chk({7'h0, soe_n[s]}, {7'h0, !e});
        if (e) chk({7'h0, sout[s]}, {7'h0, b[7 - p]});
      end
      chk({7'h0, cst}, {7'h0, hi[p][(ch + 1) % 32][1]});
    end
  initial begin
    repeat (3) @(negedge clk_sys);
    sys_rst <= 1'b0;
    gate <= 1'b1;
    acc(1'b1, 6'h1A, 8'h00);
    chk(rd, 8'h00);
    acc(1'b0, 6'h07, 8'hFF);
    acc(1'b1, 6'h00, 8'h00);
    chk(rd, 8'hDF);
    for (int m = 2; m < 4; m++)
      for (int s = 0; s < STREAMS; s++) begin
        setc({3'h0, m[1:0], s[2:0]});
        for (int c = 0; c < CHANNELS; c++) begin
          rs = xs(rs);
          lo[s][c] = (m == 2) ? rs[7:0] : lo[s][c];
          hi[s][c] = (m == 3) ? rs[2:0] : hi[s][c];
          acc(1'b0, {1'b1, c[4:0]}, m == 2 ? lo[s][c] : {5'h0, hi[s][c]});
        end
      end
    // Split mode ignores the memory select: write lands in low memory, read gives received data
    setc(8'h8C);
    acc(1'b0, 6'h27, 8'h3C);
    lo[4][7] = 8'h3C;
    @(posedge fsync);
    acc(1'b1, 6'h27, 8'h00);
    chk(rd, in_byte(4, 7));
    for (int m = 1; m < 4; m++)
      for (int s = 0; s < STREAMS; s++) begin
        setc({3'h0, m[1:0], s[2:0]});
        for (int c = 0; c < CHANNELS; c++) begin
          if (m == 1) acc(1'b0, {1'b1, c[4:0]}, 8'hA5);
          acc(1'b1, {1'b1, c[4:0]}, 8'h00);
          chk(rd, m == 1 ? in_byte(s, c) : m == 2 ? lo[s][c] : {5'h0, hi[s][c]});
        end
      end
    $display("done: memories");
    @(posedge fsync);
    chk_en = 1'b1;
    wait (bk == 480);
    chk_en = 1'b0;
    setc(8'h48);
    @(posedge fsync);
    chk_en = 1'b1;
    wait (bk == 256);
    @(negedge clk_sys);
    gate <= 1'b0;
    @(posedge fsync);
    chk_en = 1'b0;
    @(negedge clk_sys);
    gate <= 1'b1;
    run <= 1'b0;
    repeat (80) @(negedge clk_sys);
    chk(soe_n, 8'hFF);
    run <= 1'b1;
    setc(8'h10);
    acc(1'b1, 6'h27, 8'h00);
    chk(rd, lo[0][7]);
    $display("done: serial");
    test_done();
  end
endmodule

// ==== bench/tss_line_src.sv ====
// Timing source and input streams for the switch
`timescale 1ns/10ps
module tss_line_src
  import tss_pkg::*;
(
  input wire logic clk_sys,
  input wire logic run,
  output logic bit_clock_in,
  output logic frame_sync_in,
  output logic [STREAMS-1:0] serial_in_lines,
  output int ph,
  output int bk
);
  logic [7:0] b;
  // 24 clocks per bit clock; a stopped clock rests high
  always_ff @(posedge clk_sys)
    if (run) begin
      ph <= (ph == 23) ? 0 : ph + 1;
      if (ph == 23) bk <= (bk == BIT_CLK_PER_FRAME - 1) ? 0 : bk + 1;
    end
  assign bit_clock_in = !run || ph < 12;
  assign frame_sync_in = bk != 0;
  // Fixed byte per stream and channel, MSB first, new bit each cell
  always_comb
    for (int s = 0; s < STREAMS; s++) begin
      b = 8'h5A ^ {s[2:0], bk[8:4]};
      serial_in_lines[s] = b[7 - bk[3:1]];
    end
endmodule

// ==== bench/tss_switch_properties.sv ====
// Port checks for the time-slot switch
`timescale 1ns/10ps
module tss_switch_properties
  import tss_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic bit_clock_in,
  input wire logic serial_output_gate,
  input wire logic [STREAMS-1:0] serial_out_lines,
  input wire logic [STREAMS-1:0] serial_out_oe_n,
  input wire logic control_bit_serial_out,
  input wire tss_cpu_in_t cpu_in,
  input wire tss_cpu_out_t cpu_out
);
  logic bc_q;
  logic fall_q;
  int idle_q;
  // Bit clock falls, and cycles since the last one
  always_ff @(posedge clk_sys) begin
    bc_q <= bit_clock_in;
    fall_q <= bc_q & ~bit_clock_in;
    idle_q <= (bc_q & ~bit_clock_in) ? 0 : idle_q + 1;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence strobe_new;
    !cpu_in.cs_n && cpu_in.ds && !$past(cpu_in.ds);
  endsequence
  chk_gate_float: assert property (!serial_output_gate |-> &serial_out_oe_n)
    else $error("driven with gate low");
  chk_stop_float: assert property (idle_q > 62 |-> &serial_out_oe_n)
    else $error("driven with clock stopped");
  chk_ack_delay: assert property (strobe_new ##1 cpu_in.ds |-> !cpu_out.ack_oe_n)
    else $error("late ack");
  chk_ack_end: assert property (!cpu_in.ds |-> cpu_out.ack_oe_n && cpu_out.data_oe_n)
    else $error("ack after strobe");
  chk_write_quiet: assert property (!cpu_in.rw |-> cpu_out.data_oe_n)
    else $error("data driven on write");
  chk_ack_low: assert property (cpu_out.ack_o == 1'b0)
    else $error("ack level high");
  chk_ctl_timing: assert property ($changed(control_bit_serial_out) |-> fall_q)
    else $error("control bit off cell");
  chk_out_timing: assert property ($changed(serial_out_lines) |-> fall_q)
    else $error("output off cell");
endmodule
bind tss_switch tss_switch_properties u_props (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .bit_clock_in(bit_clock_in), .serial_output_gate(serial_output_gate),
  .serial_out_lines(serial_out_lines), .serial_out_oe_n(serial_out_oe_n),
  .control_bit_serial_out(control_bit_serial_out), .cpu_in(cpu_in), .cpu_out(cpu_out));

// ==== hw/tss_pkg.sv ====
// Package for the TDM time-slot switch: constants, field positions and carriers
package tss_pkg;

  // Geometry of the switch
  localparam int STREAMS = 8;
  localparam int CHANNELS = 32;
  localparam int BITS_PER_CH = 8;
  localparam int BIT_CLK_PER_FRAME = 512;

  // System clock and bit clock watchdog
  localparam int CLK_SYS_NS = 10;
  localparam int CLK_STOP_NS = 600;
  localparam int CLK_STOP_CYC = CLK_STOP_NS / CLK_SYS_NS;

  // Port address decode
  localparam int ADDR_MEM_BIT = 5;

  // Control register layout
  localparam int CTRL_SPLIT_BIT = 7;
  localparam int CTRL_MSG_BIT = 6;
  localparam int CTRL_MSEL_HI = 4;
  localparam int CTRL_MSEL_LO = 3;
  localparam int CTRL_STREAM_HI = 2;
  localparam int CTRL_STREAM_LO = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_MASK = 8'hDF;

  // Memory select codes
  localparam logic [1:0] MSEL_RSVD = 2'h0;
  localparam logic [1:0] MSEL_DATA = 2'h1;
  localparam logic [1:0] MSEL_LOW = 2'h2;
  localparam logic [1:0] MSEL_HIGH = 2'h3;

  // High connection entry layout
  localparam int CMH_MSG_BIT = 2;
  localparam int CMH_CST_BIT = 1;
  localparam int CMH_OE_BIT = 0;

  // Received-byte buffer depth
  localparam int BUF_DEPTH = 2;

  // Processor port inputs
  typedef struct packed {
    logic cs_n;
    logic ds;
    logic rw;
    logic [5:0] addr;
    logic [7:0] wdata;
  } tss_cpu_in_t;

  // Processor port outputs; enables are low while driving
  typedef struct packed {
    logic [7:0] rdata;
    logic data_oe_n;
    logic ack_o;
    logic ack_oe_n;
  } tss_cpu_out_t;

  // One received frame slot: channel number and a byte per stream
  typedef struct packed {
    logic [4:0] ch;
    logic [STREAMS-1:0][7:0] bytes;
  } tss_rx_word_t;

endpackage

// ==== hw/tss_switch.sv ====
// TDM time-slot switch: 8x32 channel switch with processor port and control serial output
`timescale 1ns/10ps
//
// Overview of operation
// - Select 01 reads received data, 10 low connection, 11 high connection memory.
// - Stream address bits choose the memory section for later channel accesses.
// - High entry bit 2 set sends low entry byte on that channel.
// - Otherwise low entry gives input stream and channel of the switched byte.
// - Gate input low floats every stream output; control serial stays driven.
// - Gate high with control bit 6 drives every output channel.
// - Gate high, bit 6 clear: high entry bit 0 enables each channel driver.
// - Bit 1 of every high entry goes out on control serial, 256 per frame.
// - Control bits lead data by one channel, streams 0 to 7 in order.
// - Stopped bit clock keeps memories and floats all stream outputs; control serial stays driven.
// - Top address bit low reaches control register; high selects channel 0-31.
// - Control bit 7 reads received data and writes low memory.
// - Control bit 6 acts as if high entry bits 2 and 0 are set.
// - Streams run at 2048 kbit/s in frames of 32 byte channels.
module tss_switch
  import tss_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic bit_clock_in,
  input wire logic frame_sync_in,
  input wire logic serial_output_gate,
  input wire logic [STREAMS-1:0] serial_in_lines,
  output logic [STREAMS-1:0] serial_out_lines,
  output logic [STREAMS-1:0] serial_out_oe_n,
  output logic control_bit_serial_out,
  input wire tss_cpu_in_t cpu_in,
  output tss_cpu_out_t cpu_out
);

  typedef enum logic [1:0] {
    CPU_IDLE,
    CPU_ACK
  } tss_cpu_state_t;

  typedef struct packed {
    logic [255:0][7:0] dmem;
    logic [255:0][7:0] cml;
    logic [255:0][2:0] cmh;
    logic [7:0] ctrl;
    logic [8:0] cnt;
    logic bclk_prev;
    logic [6:0] stop_cnt;
    logic clk_run;
    logic [STREAMS-1:0][7:0] ish;
    logic [STREAMS-1:0][7:0] obyte;
    logic [STREAMS-1:0] oen;
    logic [STREAMS-1:0] obit;
    logic cst;
    logic [BUF_DEPTH-1:0] bvalid;
    logic [BUF_DEPTH-1:0][$bits(tss_rx_word_t)-1:0] bword;
    tss_cpu_state_t cpu_st;
    logic [7:0] rdata;
  } tss_state_t;

  tss_state_t st_q;
  tss_state_t st_d;

  logic fall;
  logic [8:0] ncnt;
  logic [2:0] pos;
  logic [4:0] ch;
  logic [4:0] ch_next;
  logic [7:0] sel_addr;
  logic [7:0] byte_v;
  logic [2:0] hi_v;
  logic [7:0] shifted;
  logic msg_all;
  logic buf_in_ready;
  logic buf_out_ready;
  logic cpu_start;
  logic cpu_rd_data;
  logic [1:0] msel;
  tss_rx_word_t push_w;
  tss_rx_word_t pop_w;

  // Bit clock is an ordinary input; bit cells span two falling edges
  assign fall = st_q.bclk_prev & ~bit_clock_in;
  assign msg_all = st_q.ctrl[CTRL_MSG_BIT];
  // A processor transfer starts on strobe while chip selected and idle
  assign cpu_start = ~cpu_in.cs_n & cpu_in.ds & (st_q.cpu_st == CPU_IDLE);
  assign sel_addr = {st_q.ctrl[CTRL_STREAM_HI:CTRL_STREAM_LO], cpu_in.addr[4:0]};
  assign msel = st_q.ctrl[CTRL_MSEL_HI:CTRL_MSEL_LO];
  // Data memory read port is shared; the buffer drain yields to the processor
  assign cpu_rd_data = cpu_start & cpu_in.rw & cpu_in.addr[ADDR_MEM_BIT] &
                       (st_q.ctrl[CTRL_SPLIT_BIT] | (msel == MSEL_DATA));
  assign buf_out_ready = ~cpu_rd_data;
  assign buf_in_ready = ~st_q.bvalid[BUF_DEPTH-1];
  assign pop_w = tss_rx_word_t'(st_q.bword[0]);

  always_comb begin
    st_d = st_q;
    ncnt = st_q.cnt;
    pos = 3'h0;
    ch = 5'h00;
    ch_next = 5'h00;
    byte_v = 8'h00;
    hi_v = 3'h0;
    shifted = 8'h00;
    push_w = '0;
    st_d.bclk_prev = bit_clock_in;

    // Watchdog: no falling edge for the timeout means the bit clock stopped
    if (fall) begin
      st_d.stop_cnt = 7'h00;
      st_d.clk_run = 1'b1;
    end else if (st_q.stop_cnt == 7'(CLK_STOP_CYC)) begin
      st_d.clk_run = 1'b0;
    end else begin
      st_d.stop_cnt = st_q.stop_cnt + 7'h01;
    end

    // Buffer drain: one slot written to received-data memory per cycle
    if (st_q.bvalid[0] && buf_out_ready) begin
      for (int s = 0; s < STREAMS; s++) begin
        st_d.dmem[{3'(s), pop_w.ch}] = pop_w.bytes[s];
      end
      st_d.bword[0] = st_q.bword[1];
      st_d.bvalid = {1'b0, st_q.bvalid[1]};
    end

    if (fall) begin
      // Frame pulse low restarts the counter on this edge
      ncnt = frame_sync_in ? st_q.cnt + 9'h001 : 9'h000;
      st_d.cnt = ncnt;
      pos = ncnt[3:1];
      ch = ncnt[8:4];
      ch_next = ch + 5'h01;
      if (!ncnt[0]) begin
        // Cell start: control bit of stream pos, one channel ahead
        st_d.cst = st_q.cmh[{pos, ch_next}][CMH_CST_BIT];
        for (int s = 0; s < STREAMS; s++) begin
          if (pos == 3'h0) begin
            hi_v = st_q.cmh[{3'(s), ch}];
            if (msg_all) begin
              hi_v = 3'h7;
            end
            if (hi_v[CMH_MSG_BIT]) begin
              byte_v = st_q.cml[{3'(s), ch}];
            end else begin
              byte_v = st_q.dmem[st_q.cml[{3'(s), ch}]];
            end
            st_d.obyte[s] = byte_v;
            st_d.oen[s] = hi_v[CMH_OE_BIT];
            st_d.obit[s] = byte_v[7];
          end else begin
            st_d.obit[s] = st_q.obyte[s][3'h7 - pos];
          end
        end
      end else begin
        // Mid cell: sample inputs; last bit completes the slot
        for (int s = 0; s < STREAMS; s++) begin
          shifted = {st_q.ish[s][6:0], serial_in_lines[s]};
          st_d.ish[s] = shifted;
          push_w.bytes[s] = shifted;
        end
        push_w.ch = ch;
        if (pos == 3'h7 && buf_in_ready) begin
          // Push behind whatever stays after this cycle's drain
          if (st_d.bvalid[0]) begin
            st_d.bword[1] = push_w;
            st_d.bvalid[1] = 1'b1;
          end else begin
            st_d.bword[0] = push_w;
            st_d.bvalid[0] = 1'b1;
          end
        end
      end
    end

    // Processor port: act once per strobe, hold ack until strobe drops
    unique case (st_q.cpu_st)
      CPU_IDLE: begin
        if (cpu_start) begin
          st_d.cpu_st = CPU_ACK;
          st_d.rdata = 8'h00;
          if (!cpu_in.addr[ADDR_MEM_BIT]) begin
            if (cpu_in.rw) begin
              st_d.rdata = st_q.ctrl & CTRL_MASK;
            end else begin
              st_d.ctrl = cpu_in.wdata & CTRL_MASK;
            end
          end else if (cpu_in.rw) begin
            if (st_q.ctrl[CTRL_SPLIT_BIT] || msel == MSEL_DATA) begin
              st_d.rdata = st_q.dmem[sel_addr];
            end else if (msel == MSEL_LOW) begin
              st_d.rdata = st_q.cml[sel_addr];
            end else if (msel == MSEL_HIGH) begin
              st_d.rdata = {5'h00, st_q.cmh[sel_addr]};
            end
          end else begin
            if (st_q.ctrl[CTRL_SPLIT_BIT] || msel == MSEL_LOW) begin
              st_d.cml[sel_addr] = cpu_in.wdata;
            end else if (msel == MSEL_HIGH) begin
              st_d.cmh[sel_addr] = cpu_in.wdata[2:0];
            end
            // Data memory is read only and code 00 is reserved: writes dropped
          end
        end
      end
      CPU_ACK: begin
        if (cpu_in.cs_n || !cpu_in.ds) begin
          st_d.cpu_st = CPU_IDLE;
        end
      end
      default: begin
        st_d.cpu_st = CPU_IDLE;
      end
    endcase
  end

  // Single state register; memories clear with the rest on reset
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_q <= '0;
      st_q.ctrl <= CTRL_RESET;
      st_q.bclk_prev <= 1'b1;
      st_q.cpu_st <= CPU_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // Output drivers: gate, clock watchdog, then per-channel enable
  always_comb begin
    for (int s = 0; s < STREAMS; s++) begin
      serial_out_lines[s] = st_q.obit[s];
      serial_out_oe_n[s] = ~(serial_output_gate & st_q.clk_run &
                             (msg_all | st_q.oen[s]));
    end
  end

  assign control_bit_serial_out = st_q.cst;
  // Read data driven and ack pulled low only while the strobe holds
  assign cpu_out.rdata = st_q.rdata;
  assign cpu_out.data_oe_n = ~((st_q.cpu_st == CPU_ACK) & cpu_in.rw & cpu_in.ds & ~cpu_in.cs_n);
  assign cpu_out.ack_o = 1'b0;
  assign cpu_out.ack_oe_n = ~((st_q.cpu_st == CPU_ACK) & cpu_in.ds & ~cpu_in.cs_n);

endmodule

// ==== hw/unused_marker.sv ====
// Intentionally empty marker file
`timescale 1ns/10ps
